/* rtl/pfs_supervisor.v */
// Fault-protection supervisor with register port and interrupt.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "pfs_consts.vh"
module pfs_supervisor
#(
  parameter OTP_CYC = `PFS_OTP_CYC,
  parameter RETRY_CYC = `PFS_RETRY_CYC
)
(
  // Clock and reset.
  input wire clock,
  input wire srst,
  // Samples from the control core, millivolts, milliamps, degrees C.
  input wire [15:0] vout_mv,
  input wire [15:0] vset_mv,
  input wire [15:0] iout_ma,
  input wire [15:0] irated_ma,
  input wire [7:0] temp_c,
  input wire [15:0] track_err_mv,
  input wire ramp_up,
  // Register port.
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // Outputs.
  output reg turn_off,
  output reg output_in_window_pin,
  output reg ot_warning,
  output reg irq
);

  reg [6:0] ctrl;
  reg [3:0] oc_sel;
  reg [1:0] ov_sel;
  reg [1:0] uv_sel;
  reg win_sel;
  reg [6:0] stat;
  reg [6:0] mask;
  reg [4:0] fault;
  reg [4:0] latched;
  reg [9:0] cnt_ov;
  reg [9:0] cnt_uv;
  reg [9:0] cnt_tr;
  reg [9:0] cnt_wn;
  reg [9:0] cnt_win;
  reg [31:0] cnt_ot;
  reg [31:0] retry;
  reg output_in_window;

  // Scale a value by percent; widened so the product cannot overflow.
  function [31:0] pct;
    input [15:0] val;
    input [7:0] p;
    begin
      pct = (val * p) / 32'd100;
    end
  endfunction

  // Count cycles a condition holds; saturates at the filter length.
  function [9:0] filt;
    input cond;
    input [9:0] c;
    begin
      if (!cond)
        filt = 10'h000;
      else if (c == `PFS_FILT_CYC)
        filt = c;
      else
        filt = c + 10'h001;
    end
  endfunction

  wire [7:0] oc_pct = 8'd40 + {oc_sel, 3'b000} + {1'b0, oc_sel, 1'b0};
  wire [31:0] oc_lim = pct(irated_ma, oc_pct); // see [R02]
  wire [31:0] ov_raw = pct(vset_mv, 8'd110 + {ov_sel, 3'b000} +
    {ov_sel, 1'b0});
  wire [31:0] ov_lim = (ov_raw < `PFS_OV_FLOOR_MV) ?
    `PFS_OV_FLOOR_MV : ov_raw; // see [R04]
  wire [31:0] uv_lim = pct(vset_mv, 8'd75 + {uv_sel, 2'b00} +
    {3'b000, uv_sel}); // see [R06]
  wire [31:0] win_lo = pct(vset_mv, win_sel ? 8'd95 : 8'd90); // see [R12]
  wire [31:0] win_hi = pct(vset_mv, `PFS_WIN_HI_PCT);
  wire [15:0] tr_abs = track_err_mv[15] ? (~track_err_mv + 16'h0001) :
    track_err_mv;
  wire in_win = (vout_mv >= win_lo) && (vout_mv <= win_hi);
  wire ov_cond = vout_mv > ov_lim;
  wire uv_cond = (vout_mv < uv_lim) && !ramp_up;
  wire tr_cond = ctrl[`PFS_CTRL_TR_EN] && ramp_up &&
    (tr_abs > `PFS_TRACK_MV); // see [R09]
  wire ot_hot = temp_c >= `PFS_OTP_OFF_C;
  wire [4:0] latch_cfg = {ctrl[`PFS_CTRL_TR_LATCH], ctrl[3:0]};
  wire clear_wr = wr && (addr == `PFS_REG_CTRL) && wdata[`PFS_CTRL_CLEAR];
  // Raw trip events: oc immediate, others after their delays.
  wire [4:0] trip;
  assign trip[0] = iout_ma > oc_lim;
  assign trip[1] = cnt_ov == `PFS_FILT_CYC; // see [R05]
  assign trip[2] = cnt_uv == `PFS_FILT_CYC; // see [R05]
  assign trip[3] = cnt_ot == OTP_CYC; // see [R07]
  assign trip[4] = cnt_tr == `PFS_FILT_CYC; // see [R05]
  wire [4:0] new_trip = trip & ~fault;
  wire win_change = (cnt_win == `PFS_FILT_CYC) &&
    (output_in_window != in_win);
  wire warn_set = (cnt_wn == `PFS_FILT_CYC) && !ot_warning;
  wire [6:0] ev = {win_change, warn_set, new_trip};
  wire retry_done = (retry == RETRY_CYC - 1);
  reg [31:0] next_retry;
  reg [4:0] next_fault;

  always @*
  begin
    next_fault = fault | trip;
    next_retry = retry;
    if (clear_wr)
      next_fault = trip; // see [R14]
    else if (|(fault & ~latched))
    begin
      if (retry_done)
      begin
        // Overtemperature waits for cooling before it may restart.
        next_fault = trip | (fault & latched) |
          (fault[3] && temp_c > `PFS_OTP_ON_C ? 5'h08 : 5'h00); // see [R08]
        next_retry = 32'h0;
      end
      else
        next_retry = retry + 32'h1; // see [R01]
    end
    else
      next_retry = 32'h0;
  end

  // Software settings; out-of-range selections fold to the top step.
  always @(posedge clock)
  begin
    if (srst)
    begin
      ctrl <= 7'h00; // see [R01]
      oc_sel <= `PFS_OC_DEF; // see [R02]
      ov_sel <= `PFS_OV_DEF; // see [R03]
      uv_sel <= `PFS_UV_DEF; // see [R06]
      win_sel <= `PFS_WIN_DEF; // see [R12]
      mask <= 7'h00;
    end
    else
    begin
      if (wr && addr == `PFS_REG_CTRL)
      begin
        ctrl <= {1'b0, wdata[5:0]};
      end
      if (wr && addr == `PFS_REG_THR)
      begin
        if (wdata[3:0] > `PFS_OC_STEPS)
          oc_sel <= `PFS_OC_STEPS;
        else
          oc_sel <= wdata[3:0];
        if (wdata[5:4] == 2'h3)
          ov_sel <= 2'h2;
        else
          ov_sel <= wdata[5:4];
        uv_sel <= wdata[7:6];
        win_sel <= wdata[`PFS_THR_WIN_BIT];
      end
      if (wr && addr == `PFS_REG_MASK)
      begin
        mask <= wdata[6:0];
      end
    end
  end

  // Delay filters: each counts how long its condition has held.
  always @(posedge clock)
  begin
    if (srst)
    begin
      cnt_ov <= 10'h000;
      cnt_uv <= 10'h000;
      cnt_tr <= 10'h000;
      cnt_wn <= 10'h000;
      cnt_win <= 10'h000;
      cnt_ot <= 32'h0;
    end
    else
    begin
      cnt_ov <= filt(ov_cond, cnt_ov); // see [R05]
      cnt_uv <= filt(uv_cond, cnt_uv); // see [R05]
      cnt_tr <= filt(tr_cond, cnt_tr); // see [R05]
      cnt_wn <= filt(temp_c >= `PFS_WARN_C, cnt_wn); // see [R10]
      cnt_win <= filt(output_in_window != in_win, cnt_win); // see [R13]
      if (!ot_hot)
      begin
        cnt_ot <= 32'h0;
      end
      else if (cnt_ot != OTP_CYC)
      begin
        cnt_ot <= cnt_ot + 32'h1; // see [R07]
      end
    end
  end

  // Warning set and window output behind the filter delay; the warning clears at once.
  always @(posedge clock)
  begin
    if (srst)
    begin
      ot_warning <= 1'b0;
      output_in_window <= 1'b0;
      output_in_window_pin <= 1'b0;
    end
    else
    begin
      if (warn_set)
      begin
        ot_warning <= 1'b1; // see [R11]
      end
      else if (temp_c <= `PFS_WARN_C - `PFS_WARN_HYST_C)
      begin
        ot_warning <= 1'b0; // see [R11]
      end
      if (win_change)
      begin
        output_in_window <= in_win;
        output_in_window_pin <= in_win; // see [R13]
      end
    end
  end

  // Fault state and the turn-off command.
  always @(posedge clock)
  begin
    if (srst)
    begin
      fault <= 5'h00;
      latched <= 5'h00;
      retry <= 32'h0;
      turn_off <= 1'b0;
    end
    else
    begin
      fault <= next_fault;
      latched <= (latched | (new_trip & latch_cfg)) & next_fault; // see [R14]
      retry <= next_retry;
      turn_off <= |next_fault;
    end
  end

  wire stat_rd = rd && (addr == `PFS_REG_STAT);
  reg [6:0] next_stat;
  reg [31:0] next_rdata;

  // Status bits are sticky; a read clears them, but a new event wins.
  always @*
  begin
    if (stat_rd)
      next_stat = ev;
    else
      next_stat = stat | ev;
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      stat <= 7'h00;
      irq <= 1'b0;
    end
    else
    begin
      stat <= next_stat;
      irq <= |(next_stat & mask);
    end
  end

  // Read data mux; idle and unmapped cycles read as zero.
  always @*
  begin
    next_rdata = 32'h0;
    if (rd)
    begin
      case (addr)
        `PFS_REG_CTRL:
        begin
          next_rdata = {25'h0, ctrl};
        end
        `PFS_REG_THR:
        begin
          next_rdata = {23'h0, win_sel, uv_sel, ov_sel, oc_sel};
        end
        `PFS_REG_STAT:
        begin
          next_rdata = {25'h0, stat};
        end
        `PFS_REG_MASK:
        begin
          next_rdata = {25'h0, mask};
        end
        `PFS_REG_LIVE:
        begin
          next_rdata = {20'h0, latched, ot_warning, output_in_window, fault};
        end
        default:
        begin
          next_rdata = 32'h0;
        end
      endcase
    end
  end

  always @(posedge clock)
  begin
    if (srst)
      rdata <= 32'h0;
    else
      rdata <= next_rdata;
  end

endmodule

/* rtl/pfs_consts.vh */
// Constants for the point-of-load fault-protection supervisor.
// Behaviour
// [R01] Current and voltage faults latch or retry 130 ms
// [R02] Overcurrent limit 11 steps, 40-140 %, default 140
// [R03] Overvoltage limit 110-130 % by 10, default 130
// [R04] Overvoltage trip level never below 1.0 V
// [R05] Voltage and tracking faults turn off after 6 us
// [R06] Undervoltage limit 75-90 % by 5, default 75
// [R07] Overtemperature at 120 C turns off after 2 ms
// [R08] Overtemperature restart only below 110 C; code also restarts at 110 C
// [R09] Tracking check off by default, ramp only, 250 mV
// [R10] Overtemperature warning always evaluated at 120 C
// [R11] Warning after 6 us, clears 3 C below threshold
// [R12] Power good inside 110 % and 90/95 % window
// [R13] Power good changes 6 us after crossing
// [R14] Latched fault holds off until explicit clear
// [R15] Core supplies samples and settings each clock
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH
`define PFS_CLK_MHZ 100
`define PFS_FILT_US 6
`define PFS_FILT_CYC (`PFS_FILT_US * `PFS_CLK_MHZ)
`define PFS_OTP_MS 2
`define PFS_OTP_CYC (`PFS_OTP_MS * 1000 * `PFS_CLK_MHZ)
`define PFS_RETRY_MS 130
`define PFS_RETRY_CYC (`PFS_RETRY_MS * 1000 * `PFS_CLK_MHZ)
`define PFS_OTP_OFF_C 120
`define PFS_OTP_ON_C 110
`define PFS_WARN_C 120
`define PFS_WARN_HYST_C 3
`define PFS_TRACK_MV 250
`define PFS_OV_FLOOR_MV 1000
`define PFS_WIN_HI_PCT 110
// Register offsets (byte addresses).
`define PFS_REG_CTRL 8'h00
`define PFS_REG_THR 8'h04
`define PFS_REG_STAT 8'h08
`define PFS_REG_MASK 8'h0c
`define PFS_REG_LIVE 8'h10
// Control register fields.
`define PFS_CTRL_OC_LATCH 0
`define PFS_CTRL_OV_LATCH 1
`define PFS_CTRL_UV_LATCH 2
`define PFS_CTRL_OT_LATCH 3
`define PFS_CTRL_TR_EN 4
`define PFS_CTRL_TR_LATCH 5
`define PFS_CTRL_CLEAR 6
// Threshold register fields and reset values.
`define PFS_THR_OC_LSB 0
`define PFS_THR_OV_LSB 4
`define PFS_THR_UV_LSB 6
`define PFS_THR_WIN_BIT 8
`define PFS_OC_STEPS 4'd10
`define PFS_OC_DEF 4'ha
`define PFS_OV_DEF 2'h2
`define PFS_UV_DEF 2'h0
`define PFS_WIN_DEF 1'b0
// Status bits: 0 oc, 1 ov, 2 uv, 3 ot, 4 track, 5 warn, 6 window change.
`define PFS_NEV 7
`endif

/* tb/pfs_props.sv */
// Checker for the supervisor outputs, bound to the supervisor.
`timescale 1ns/1ns
module pfs_props #(parameter RETRY_CYC = 2000)
(
  // Clock and reset.
  input wire clock,
  input wire srst,
  // Watched ports.
  input wire [15:0] vout_mv,
  input wire [15:0] vset_mv,
  input wire [7:0] temp_c,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire turn_off,
  input wire output_in_window_pin,
  input wire ot_warning,
  input wire irq
);
  reg [31:0] hot = 0;
  reg [31:0] off = 0;
  wire clr_src = (rd && addr == 8'h08) || (wr && addr == 8'h0c);
  wire clr_wr = wr && addr == 8'h00 && wdata[6];
  always @(posedge clock)
  begin
    hot <= (temp_c >= 8'd120 && !srst) ? hot + 32'd1 : 32'd0;
    off <= (turn_off && !srst) ? off + 32'd1 : 32'd0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  chk_rdata_idle:
    assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata idle");
  chk_rdata_unmap:
    assert property ($past(rd && addr > 8'h10) |-> rdata == 32'h0)
    else $error("unmapped read");
  chk_window_upper:
    assert property ($rose(output_in_window_pin) |->
      $past({16'h0, vout_mv} * 100 <= {16'h0, vset_mv} * 110))
    else $error("pg above window");
  chk_warn_delay:
    assert property ($rose(ot_warning) |-> hot >= 32'd599)
    else $error("warning early");
  chk_warn_clear:
    assert property (ot_warning && temp_c <= 8'd117 |=> !ot_warning)
    else $error("warning kept");
  chk_warn_hold:
    assert property (ot_warning && temp_c > 8'd117 |=> ot_warning)
    else $error("warning dropped");
  chk_irq_fall:
    assert property ($fell(irq) |-> $past(clr_src) || $past(clr_src, 2))
    else $error("irq fell alone");
  chk_retry_wait:
    assert property ($fell(turn_off) |-> off >= RETRY_CYC - 3 ||
      $past(clr_wr) || $past(clr_wr, 2)) else $error("early restart");
  cover property ($rose(turn_off));
  cover property ($fell(turn_off));
  cover property ($rose(ot_warning));
  cover property ($rose(irq));
endmodule
bind pfs_supervisor pfs_props #(.RETRY_CYC(RETRY_CYC)) i_pfs_props (
  .clock(clock), .srst(srst), .vout_mv(vout_mv), .vset_mv(vset_mv),
  .temp_c(temp_c), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .turn_off(turn_off), .ot_warning(ot_warning),
  .output_in_window_pin(output_in_window_pin), .irq(irq));

/* tb/pfs_plant.sv */
// Model of the power stage and its sensing.
`timescale 1ns/1ns
module pfs_plant
(
  // Clock and turn-off command.
  input wire clock,
  input wire off,
  // Targets from the bench.
  input wire [15:0] v_t,
  input wire [15:0] i_t,
  input wire [7:0] t_t,
  // Samples to the supervisor.
  output reg [15:0] vout_mv,
  output reg [15:0] iout_ma,
  output reg [7:0] temp_c
);
  // Current collapses while the stage is held off.
  always @(posedge clock)
  begin
    vout_mv <= v_t;
    iout_ma <= off ? 16'h0 : i_t;
    temp_c <= t_t;
  end
endmodule

/* tb/tb.sv */
// Self-checking bench for the fault-protection supervisor.
`timescale 1ns/1ns
module tb;
  reg clock = 0, srst = 1, wr = 0, rd = 0, ramp_up = 0;
  reg [7:0] addr = 0, t_t = 25;
  reg [31:0] wdata = 0;
  reg [15:0] vset_mv = 1000, irated_ma = 1000, track_err_mv = 0;
  reg [15:0] v_t = 1000, i_t = 100;
  wire [15:0] vout_mv, iout_ma;
  wire [7:0] temp_c;
  wire [31:0] rdata;
  wire turn_off, output_in_window_pin, ot_warning, irq;
  int error_cnt = 0, tests_run = 0, k, v;
  always #5 clock = ~clock;
  pfs_plant i_pfs_plant (.clock(clock), .off(turn_off), .v_t(v_t),
    .i_t(i_t), .t_t(t_t), .vout_mv(vout_mv), .iout_ma(iout_ma),
    .temp_c(temp_c));
  pfs_supervisor #(.OTP_CYC(50), .RETRY_CYC(2000)) i_pfs_supervisor (
    .clock(clock), .srst(srst), .vout_mv(vout_mv), .vset_mv(vset_mv),
    .iout_ma(iout_ma), .irated_ma(irated_ma), .temp_c(temp_c),
    .track_err_mv(track_err_mv), .ramp_up(ramp_up), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .turn_off(turn_off),
    .output_in_window_pin(output_in_window_pin), .ot_warning(ot_warning),
    .irq(irq));
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clock);
    wr <= 0;
  endtask
  task rdr(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1;
    @(posedge clock);
    rd <= 0;
    #1 chk("rdata", rdata, e);
  endtask
  task wt(input logic w, input int n);
    repeat (n) if (turn_off !== w) cyc(1);
    chk("turn_off wait", turn_off, w);
    if (turn_off !== w) give_verdict;
  endtask
  task trip(input string nm, input int n);
    cyc(n - 20);
    chk(nm, turn_off, 0);
    cyc(20);
    chk(nm, turn_off, 1);
  endtask
  initial
  begin
    k = $urandom(32'h1013efc6);
    cyc(5);
    srst <= 0;
    for (k = 0; k < 6; k++)
      rdr(k == 5 ? 8'h20 : 8'(k * 4), k == 1 ? 32'h2a : 0);
    cyc(570);
    chk("pg early", output_in_window_pin, 0);
    cyc(30);
    chk("pg", output_in_window_pin, 1);
    wrr(8'h04, 32'h12a);
    for (k = 0; k < 3; k++)
    begin
      v = 900 + $urandom % 200;
      v_t <= 16'(v);
      cyc(700);
      chk("pg95", output_in_window_pin, v >= 950 && v <= 1100);
    end
    wrr(8'h04, 32'h2a);
    v_t <= 1000;
    cyc(700);
    rdr(8'h08, 32'h40);
    wrr(8'h0c, 32'h02);
    v_t <= 1350;
    trip("ov", 610);
    chk("irq", irq, 1);
    v_t <= 1000;
    rdr(8'h08, 32'h42);
    cyc(2);
    chk("irq clr", irq, 0);
    wt(0, 2100);
    cyc(700);
    chk("irq mask", irq, 0);
    wrr(8'h00, 32'h02);
    v_t <= 1350;
    cyc(610);
    v_t <= 1000;
    cyc(2100);
    chk("latched", turn_off, 1);
    wrr(8'h00, 32'h42);
    wt(0, 5);
    wrr(8'h00, 32'h0);
    wrr(8'h04, 32'h0a);
    vset_mv <= 600;
    v_t <= 950;
    cyc(700);
    chk("ov floor", turn_off, 0);
    v_t <= 1050;
    trip("ov floor", 610);
    vset_mv <= 1000;
    v_t <= 1000;
    wrr(8'h04, 32'hea);
    wt(0, 2100);
    v_t <= 880;
    trip("uv", 610);
    v_t <= 1000;
    wt(0, 2100);
    t_t <= 125;
    trip("ot", 60);
    cyc(550);
    chk("warn", ot_warning, 1);
    t_t <= 118;
    cyc(5);
    chk("warn hyst", ot_warning, 1);
    t_t <= 112;
    cyc(3);
    chk("warn clr", ot_warning, 0);
    cyc(2100);
    chk("ot hold", turn_off, 1);
    t_t <= 110;
    wt(0, 2100);
    for (k = 0; k < 2; k++)
    begin
      wrr(8'h04, k ? 32'h2f : 32'h20);
      i_t <= k ? 16'd1390 : 16'd390;
      cyc(5);
      chk("oc below", turn_off, 0);
      i_t <= i_t + 16'd20;
      cyc(4);
      chk("oc trip", turn_off, 1);
      i_t <= 100;
      wt(0, 2100);
    end
    ramp_up <= 1;
    track_err_mv <= 16'hfed4;
    cyc(700);
    chk("track off", turn_off, 0);
    wrr(8'h00, 32'h10);
    trip("track", 610);
    give_verdict;
  end
endmodule
